// ### hw/hvm_pkg.sv
package hvm_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_GPIO  = 8'h04;
    localparam logic [7:0] OFF_PULL  = 8'h08;
    localparam logic [7:0] OFF_WAKE  = 8'h0c;
    localparam logic [7:0] OFF_CMD   = 8'h10;
    localparam logic [7:0] OFF_STAT  = 8'h14;
    localparam logic [7:0] OFF_CLR   = 8'h18;
    localparam logic [7:0] OFF_IEN   = 8'h1c;
    localparam logic [7:0] OFF_LVL   = 8'h20;

    // field positions
    localparam int CTRL_MEAS   = 0;
    localparam int CTRL_FOTEST = 1;
    localparam int WAKE_HV     = 0;
    localparam int WAKE_GPIO   = 1;
    localparam int CMD_SLEEP   = 0;
    localparam int STAT_ERR    = 0;
    localparam int STAT_HV     = 1;
    localparam int STAT_GPIO   = 2;
    localparam int STAT_W      = 3;
    localparam int PIN_HV      = 0;
    localparam int PIN_FG      = 1;

    // fail_gpio_pin configuration codes
    localparam logic [2:0] GPIO_OFF = 3'h0;
    localparam logic [2:0] GPIO_FO  = 3'h1;
    localparam logic [2:0] GPIO_HS  = 3'h2;
    localparam logic [2:0] GPIO_LS  = 3'h3;
    localparam logic [2:0] GPIO_WK  = 3'h4;

    // reset values
    localparam logic [1:0]        RST_CTRL = 2'h0;
    localparam logic [2:0]        RST_GPIO = 3'h0;
    localparam logic [3:0]        RST_PULL = 4'h0;
    localparam logic [1:0]        RST_WAKE = 2'h0;
    localparam logic [STAT_W-1:0] RST_STAT = 3'h0;
    localparam logic [STAT_W-1:0] RST_IEN  = 3'h0;

    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } hvm_mode_t;

    typedef struct packed {
        logic pull_up;
        logic pull_dn;
    } hvm_pull_t;

endpackage : hvm_pkg

// ### hw/hvm_measure_ctrl.sv
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module hvm_measure_ctrl
    import hvm_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              resetn_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // chip state
    input  wire hvm_mode_t         sbc_mode_i,
    input  wire logic              fail_req_i,
    input  wire logic              other_wake_i,
    // pins
    input  wire logic              hv_sense_i,
    input  wire logic              fail_gpio_i,
    output logic                   fail_gpio_o,
    output logic                   fail_gpio_oe_o,
    output hvm_pull_t [1:0]        pin_pull_o,
    output logic                   measure_switch_o,
    // mode requests and wake
    output logic                   sleep_req_o,
    output logic                   restart_req_o,
    output logic                   hv_wake_active_o,
    output logic                   irq_o
);

    // register state
    logic              measure_enable;
    logic              fail_output_test;
    logic [2:0]        gpio_config;
    logic [3:0]        wake_pull_config;
    logic [1:0]        wake_control_1;
    logic [STAT_W-1:0] irq_status;
    logic [STAT_W-1:0] irq_enable;
    logic [1:0]        wake_level_status;

    // pin synchronisers and stable levels
    logic [1:0]        sync_a;
    logic [1:0]        sync_b;
    logic [1:0]        sync_c;
    logic [1:0]        pin_level;

    // apb decode
    wire setup_rd = psel_i & ~penable_i & ~pwrite_i;
    wire wr_en    = psel_i & penable_i & pwrite_i;
    wire hit_ctrl = (paddr_i == OFF_CTRL);
    wire hit_gpio = (paddr_i == OFF_GPIO);
    wire hit_pull = (paddr_i == OFF_PULL);
    wire hit_wake = (paddr_i == OFF_WAKE);
    wire hit_cmd  = (paddr_i == OFF_CMD);
    wire hit_stat = (paddr_i == OFF_STAT);
    wire hit_clr  = (paddr_i == OFF_CLR);
    wire hit_ien  = (paddr_i == OFF_IEN);
    wire hit_lvl  = (paddr_i == OFF_LVL);
    wire mapped   = hit_ctrl | hit_gpio | hit_pull | hit_wake | hit_cmd
                  | hit_stat | hit_clr | hit_ien | hit_lvl;
    wire wr_ctrl  = wr_en & hit_ctrl;
    wire wr_gpio  = wr_en & hit_gpio;
    wire wr_pull  = wr_en & hit_pull;
    wire wr_wake  = wr_en & hit_wake;
    wire wr_cmd   = wr_en & hit_cmd;
    wire wr_clr   = wr_en & hit_clr;
    wire wr_ien   = wr_en & hit_ien;

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // enable request and its refusal
    wire meas_req   = pwdata_i[CTRL_MEAS];
    wire en_refused = wr_ctrl & meas_req & ~measure_enable
                    & (gpio_config != GPIO_OFF);
    wire next_measure_enable = wr_ctrl ? (meas_req & ~en_refused)
                                       : measure_enable;
    wire is_normal = (sbc_mode_i == MODE_NORMAL);
    wire next_switch = next_measure_enable & is_normal;

    // gpio change while measuring
    wire gpio_err = wr_gpio & measure_enable
                  & (pwdata_i[2:0] != gpio_config);

    // sleep command check
    wire gpio_is_wk = (gpio_config == GPIO_WK);
    wire pin_src    = wake_control_1[WAKE_HV]
                    | (gpio_is_wk & wake_control_1[WAKE_GPIO]);
    wire sleep_cmd  = wr_cmd & pwdata_i[CMD_SLEEP];
    wire sleep_bad  = sleep_cmd & measure_enable & pin_src
                    & ~other_wake_i;

    // pin input processing, gated while measuring
    wire [1:0] agree   = ~(sync_b ^ sync_c);
    wire [1:0] pin_chg = agree & (sync_b ^ pin_level) & {2{~measure_enable}};
    wire hv_arm  = ~measure_enable
                 & (wake_control_1[WAKE_HV]
                    | (sbc_mode_i == MODE_FAILSAFE));
    wire gpio_arm = ~measure_enable & gpio_is_wk
                  & wake_control_1[WAKE_GPIO];
    wire next_hv_arm = ~next_measure_enable
                     & (wake_control_1[WAKE_HV]
                        | (sbc_mode_i == MODE_FAILSAFE));

    // sticky status, set wins over clear
    wire [STAT_W-1:0] stat_set;
    assign stat_set[STAT_ERR]  = en_refused | gpio_err | sleep_bad;
    assign stat_set[STAT_HV]   = pin_chg[PIN_HV] & hv_arm;
    assign stat_set[STAT_GPIO] = pin_chg[PIN_FG] & gpio_arm;
    wire [STAT_W-1:0] stat_clr = wr_clr ? pwdata_i[STAT_W-1:0]
                                        : {STAT_W{1'b0}};
    wire [STAT_W-1:0] next_status = (irq_status & ~stat_clr) | stat_set;

    assign irq_o = |(irq_status & irq_enable);

    // fail_gpio_pin drive, all off while measuring
    wire fo_active = (gpio_config == GPIO_FO)
                   & (fail_req_i | fail_output_test);
    wire drv_hs    = (gpio_config == GPIO_HS);
    wire drv_ls    = (gpio_config == GPIO_LS);
    wire next_oe   = ~next_measure_enable
                   & (fo_active | drv_hs | drv_ls);
    wire next_out  = drv_hs;

    // pull currents follow config only when not measuring
    wire [3:0] next_pull = next_measure_enable ? 4'h0
                                               : wake_pull_config;

    // read mux
    wire [31:0] rd_val =
        hit_ctrl ? {30'h0, fail_output_test, measure_enable} :
        hit_gpio ? {29'h0, gpio_config} :
        hit_pull ? {28'h0, wake_pull_config} :
        hit_wake ? {30'h0, wake_control_1} :
        hit_stat ? {29'h0, irq_status} :
        hit_ien  ? {29'h0, irq_enable} :
        hit_lvl  ? {29'h0, measure_switch_o, wake_level_status} :
                   32'h0;

    // configuration registers, stored even while measuring
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            measure_enable   <= RST_CTRL[CTRL_MEAS];
            fail_output_test <= RST_CTRL[CTRL_FOTEST];
            gpio_config      <= RST_GPIO;
            wake_pull_config <= RST_PULL;
            wake_control_1   <= RST_WAKE;
            irq_enable       <= RST_IEN;
        end else begin
            measure_enable <= next_measure_enable;
            if (wr_ctrl) begin
                fail_output_test <= pwdata_i[CTRL_FOTEST];
            end
            if (wr_gpio) begin
                gpio_config <= pwdata_i[2:0];
            end
            if (wr_pull) begin
                wake_pull_config <= pwdata_i[3:0];
            end
            if (wr_wake) begin
                wake_control_1 <= pwdata_i[1:0];
            end
            if (wr_ien) begin
                irq_enable <= pwdata_i[STAT_W-1:0];
            end
        end
    end

    // status, pin levels and synchronisers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_status        <= RST_STAT;
            sync_a            <= 2'h0;
            sync_b            <= 2'h0;
            sync_c            <= 2'h0;
            pin_level         <= 2'h0;
            wake_level_status <= 2'h0;
        end else begin
            irq_status <= next_status;
            sync_a     <= {fail_gpio_i, hv_sense_i};
            sync_b     <= sync_a;
            sync_c     <= sync_b;
            if (!measure_enable) begin
                pin_level         <= (pin_level & ~agree)
                                   | (sync_b & agree);
                wake_level_status <= pin_level;
            end
        end
    end

    // registered outputs
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            measure_switch_o <= 1'b0;
            pin_pull_o       <= '0;
            fail_gpio_o      <= 1'b0;
            fail_gpio_oe_o   <= 1'b0;
            hv_wake_active_o <= 1'b0;
            sleep_req_o      <= 1'b0;
            restart_req_o    <= 1'b0;
            prdata_o         <= 32'h0;
        end else begin
            measure_switch_o <= next_switch;
            pin_pull_o       <= next_pull;
            fail_gpio_o      <= next_out;
            fail_gpio_oe_o   <= next_oe;
            hv_wake_active_o <= next_hv_arm;
            sleep_req_o      <= sleep_cmd & ~sleep_bad;
            restart_req_o    <= sleep_bad;
            if (setup_rd) begin
                prdata_o <= rd_val;
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    a_switch_closes: assert property (
        (measure_enable && is_normal && !wr_ctrl) |=> measure_switch_o)
        else $error("switch not closed in normal mode");

    a_switch_open_else: assert property (
        !is_normal |=> !measure_switch_o)
        else $error("switch closed outside normal mode");

    a_enable_kept: assert property (
        (measure_enable && !is_normal && !wr_ctrl) |=> measure_enable)
        else $error("measure enable lost outside normal mode");

    a_pulls_off: assert property (
        measure_enable |-> (pin_pull_o == '0))
        else $error("pull current active while measuring");

    a_wake_stat_hold: assert property (
        $past(measure_enable) |->
            !$rose(irq_status[STAT_HV]) && !$rose(irq_status[STAT_GPIO]))
        else $error("wake status set while measuring");

    a_level_hold: assert property (
        (measure_enable && $past(measure_enable)) |=>
            $stable(wake_level_status))
        else $error("wake level changed while measuring");

    a_sleep_refused: assert property (
        sleep_bad |=> restart_req_o && !sleep_req_o
                      && irq_status[STAT_ERR])
        else $error("sleep not refused while measuring");

    a_pin_quiet: assert property (
        measure_enable |-> !fail_gpio_oe_o)
        else $error("fail_gpio driven while measuring");

    a_gpio_err: assert property (
        gpio_err |=> irq_status[STAT_ERR]
                     && (gpio_config == $past(pwdata_i[2:0])))
        else $error("gpio change not flagged or not stored");

    a_enable_refused: assert property (
        en_refused |=> irq_status[STAT_ERR])
        else $error("refused enable not flagged");

    a_refused_off: assert property (
        en_refused |=> !measure_enable ##1 !measure_switch_o)
        else $error("refused enable changed state");

    a_no_auto_wake: assert property (
        measure_enable |-> !hv_wake_active_o)
        else $error("hv wake armed while measuring");

    a_pull_stored: assert property (
        (wr_pull && measure_enable) |=>
            (wake_pull_config == $past(pwdata_i[3:0])))
        else $error("pull setting not stored while measuring");

    a_wake_stored: assert property (
        (wr_wake && measure_enable) |=>
            (wake_control_1 == $past(pwdata_i[1:0])))
        else $error("wake setting not stored while measuring");

    a_gpio_drive: assert property (
        (!measure_enable && !wr_ctrl && drv_hs) |=>
            (fail_gpio_oe_o && fail_gpio_o))
        else $error("high side drive missing while not measuring");

    a_sleep_passed: assert property (
        (sleep_cmd && !sleep_bad) |=> (sleep_req_o && !restart_req_o))
        else $error("accepted sleep not passed on");

endmodule : hvm_measure_ctrl

// ### sim/hvm_pin_model.sv
`timescale 1ns/1ps
// far side of both pins: battery on hv_sense, divider and load on fail_gpio
module hvm_pin_model
    import hvm_pkg::*;
(
    // clock
    input  wire logic            core_clk_i,
    // pin levels and block drive
    input  wire logic            hv_level_i,
    input  wire logic            fail_gpio_drv_i,
    input  wire logic            fail_gpio_oe_i,
    input  wire logic            measure_switch_i,
    input  wire hvm_pull_t [1:0] pin_pull_i,
    // resolved pins
    output logic                 hv_sense_o,
    output logic                 fail_gpio_pin_o
);
    logic float_val = 1'b0;
    // an undriven pin without pull shows a changing pattern, not a held value
    always_ff @(posedge core_clk_i) begin
        float_val <= ~float_val;
    end
    assign hv_sense_o      = hv_level_i;
    assign fail_gpio_pin_o = measure_switch_i ? hv_level_i :
                             fail_gpio_oe_i ? fail_gpio_drv_i :
                             pin_pull_i[PIN_FG].pull_up ? 1'b1 :
                             pin_pull_i[PIN_FG].pull_dn ? 1'b0 : float_val;
endmodule : hvm_pin_model

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
    import hvm_pkg::*;
    logic            clk, rstn, psel, pen, pwr, fail_req, oth_wake, hv_lvl;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic            pready, pslverr, err, hv_s, fg_i, fg_o, fg_oe, sw;
    logic            slp, rst_req, hv_wk, irq, s_seen, r_seen;
    hvm_pull_t [1:0] pull;
    hvm_mode_t       mode;
    int              error_cnt, checks;

    hvm_measure_ctrl u_dut (.core_clk_i(clk), .resetn_i(rstn),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sbc_mode_i(mode), .fail_req_i(fail_req),
        .other_wake_i(oth_wake), .hv_sense_i(hv_s), .fail_gpio_i(fg_i),
        .fail_gpio_o(fg_o), .fail_gpio_oe_o(fg_oe), .pin_pull_o(pull),
        .measure_switch_o(sw), .sleep_req_o(slp), .restart_req_o(rst_req),
        .hv_wake_active_o(hv_wk), .irq_o(irq));
    hvm_pin_model u_pins (.core_clk_i(clk), .hv_level_i(hv_lvl),
        .fail_gpio_drv_i(fg_o), .fail_gpio_oe_i(fg_oe),
        .measure_switch_i(sw), .pin_pull_i(pull), .hv_sense_o(hv_s),
        .fail_gpio_pin_o(fg_i));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task final_report;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // one apb transfer, request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        #1;
    endtask : apb

    task wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task pulses;
        s_seen = slp;
        r_seen = rst_req;
        repeat (2) begin
            @(posedge clk);
            #1;
            s_seen |= slp;
            r_seen |= rst_req;
        end
    endtask : pulses

    task t_reset;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, sw}, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, OFF_PULL, 32'h9);
        wait_cyc(1);
        chk({28'h0, pull}, 32'h9);
        apb(1'b1, OFF_WAKE, 32'h1);
        wait_cyc(1);
        chk({31'h0, hv_wk}, 32'h1);
        @(posedge clk) hv_lvl <= 1'b1;
        wait_cyc(8);
        apb(1'b0, OFF_STAT, 32'h0);
        chk({31'h0, rd[STAT_HV]}, 32'h1);
        apb(1'b1, OFF_CLR, 32'h7);
    endtask : t_reset

    task t_refuse;
        @(posedge clk) fail_req <= 1'b1;
        apb(1'b1, OFF_GPIO, {29'h0, GPIO_FO});
        wait_cyc(1);
        chk({30'h0, fg_oe, fg_o}, 32'h2);
        for (int c = 1; c < 5; c++) begin
            apb(1'b1, OFF_GPIO, c);
            wait_cyc(1);
            chk({30'h0, fg_oe, fg_o}, {30'h0, c != 4, c == 2});
            apb(1'b1, OFF_CTRL, 32'h1);
            chk({31'h0, sw}, 32'h0);
            apb(1'b0, OFF_CTRL, 32'h0);
            chk({31'h0, rd[CTRL_MEAS]}, 32'h0);
            apb(1'b0, OFF_STAT, 32'h0);
            chk({31'h0, rd[STAT_ERR]}, 32'h1);
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, OFF_IEN, 32'h1);
            chk({31'h0, irq}, 32'h1);
            apb(1'b1, OFF_CLR, 32'h1);
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, OFF_IEN, 32'h0);
        end
    endtask : t_refuse

    task t_measure;
        apb(1'b1, OFF_GPIO, {29'h0, GPIO_OFF});
        apb(1'b1, OFF_CTRL, 32'h1);
        chk({31'h0, sw}, 32'h1);
        chk({28'h0, pull}, 32'h0);
        apb(1'b1, OFF_PULL, 32'h6);
        wait_cyc(1);
        chk({28'h0, pull}, 32'h0);
        apb(1'b0, OFF_PULL, 32'h0);
        chk(rd, 32'h6);
        apb(1'b1, OFF_GPIO, {29'h0, GPIO_FO});
        apb(1'b1, OFF_CTRL, 32'h3);
        wait_cyc(1);
        chk({31'h0, fg_oe}, 32'h0);
        apb(1'b0, OFF_STAT, 32'h0);
        chk({31'h0, rd[STAT_ERR]}, 32'h1);
        apb(1'b0, OFF_GPIO, 32'h0);
        chk(rd, {29'h0, GPIO_FO});
        apb(1'b1, OFF_GPIO, {29'h0, GPIO_OFF});
        apb(1'b1, OFF_CLR, 32'h7);
        apb(1'b1, OFF_WAKE, 32'h3);
        apb(1'b0, OFF_WAKE, 32'h0);
        chk(rd, 32'h3);
        @(posedge clk) hv_lvl <= 1'b0;
        wait_cyc(8);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFF_LVL, 32'h0);
        chk({30'h0, rd[2], rd[PIN_HV]}, 32'h3);
        chk({31'h0, hv_wk}, 32'h0);
    endtask : t_measure

    task t_modes;
        @(posedge clk) mode <= MODE_STOP;
        wait_cyc(3);
        chk({31'h0, sw}, 32'h0);
        @(posedge clk) mode <= MODE_NORMAL;
        wait_cyc(3);
        chk({31'h0, sw}, 32'h1);
        @(posedge clk) mode <= MODE_FAILSAFE;
        wait_cyc(3);
        chk({30'h0, sw, hv_wk}, 32'h0);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk({31'h0, rd[CTRL_MEAS]}, 32'h1);
        @(posedge clk) mode <= MODE_NORMAL;
        wait_cyc(3);
    endtask : t_modes

    task t_sleep;
        @(posedge clk) oth_wake <= 1'b0;
        apb(1'b1, OFF_CMD, 32'h1);
        pulses();
        chk({30'h0, s_seen, r_seen}, 32'h1);
        apb(1'b0, OFF_STAT, 32'h0);
        chk({31'h0, rd[STAT_ERR]}, 32'h1);
        apb(1'b1, OFF_CLR, 32'h7);
        @(posedge clk) oth_wake <= 1'b1;
        apb(1'b1, OFF_CMD, 32'h1);
        pulses();
        chk({30'h0, s_seen, r_seen}, 32'h2);
    endtask : t_sleep

    // reset in mid-run while measuring
    task t_rearm;
        @(posedge clk) rstn <= 1'b0;
        wait_cyc(2);
        chk({29'h0, sw, fg_oe, hv_wk}, 32'h0);
        chk({28'h0, pull}, 32'h0);
        @(posedge clk) rstn <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFF_PULL, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, sw}, 32'h0);
    endtask : t_rearm

    initial begin
        error_cnt = 0;
        checks    = 0;
        rstn      = 1'b0;
        psel      = 1'b0;
        pen       = 1'b0;
        pwr       = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        fail_req  = 1'b0;
        oth_wake  = 1'b0;
        hv_lvl    = 1'b0;
        mode      = MODE_INIT;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        mode <= MODE_NORMAL;
        t_reset();
        t_refuse();
        t_measure();
        t_modes();
        t_sleep();
        t_rearm();
        final_report();
    end

    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
endmodule : tb
